// >>> dms_cfg.svh
// Constants for the data-path mux select decoder: opcodes, slot, literals, offsets.
// Assumes inclusion by dms_pkg.sv and the test bench before any use.
`ifndef DMS_CFG_SVH
`define DMS_CFG_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define DMS_SLOT_T12       4'hc

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define DMS_OP_D0          8'hd0
`define DMS_OP_D1          8'hd1
`define DMS_OP_D2          8'hd2
`define DMS_OP_D3          8'hd3
`define DMS_OP_D4          8'hd4
`define DMS_OP_D8          8'hd8
`define DMS_OP_DC          8'hdc
`define DMS_OP_E0          8'he0
`define DMS_OP_E1          8'he1
`define DMS_OP_E2          8'he2
`define DMS_OP_E3          8'he3
`define DMS_OP_E4          8'he4
`define DMS_OP_E8          8'he8
`define DMS_OP_EC          8'hec
`define DMS_OP_F0          8'hf0
`define DMS_OP_F1          8'hf1
`define DMS_OP_F2          8'hf2
`define DMS_OP_F3          8'hf3
`define DMS_OP_F4          8'hf4
`define DMS_OP_F8          8'hf8
`define DMS_OP_ERE_SET     8'hb7
`define DMS_OP_ERE_CLR     8'hbf

// ----------------------------------------
// Hard-wired characters and fixed address
// ----------------------------------------
`define DMS_PAD_CHAR       8'hff
`define DMS_ACK_CHAR       8'h0e
`define DMS_KS_RAM_ADDR    8'h30

// ----------------------------------------
// Register map and reset values
// ----------------------------------------
`define DMS_OFS_CTRL       4'h0
`define DMS_OFS_STATUS     4'h4
`define DMS_OFS_LASTOP     4'h8
`define DMS_CTRL_RST       1'h1

`endif

// >>> dms_pkg.sv
// Types shared by the data-path mux select decoder.
// Assumes dms_cfg.svh sits in the same folder.
`default_nettype none
`include "dms_cfg.svh"

package dms_pkg;

	// ----------------------------------------
	// Mux source enumerations
	// ----------------------------------------
	typedef enum logic [2:0] {RAM_A, RAM_B, RAM_JDR, RAM_FDR, RAM_KS, RAM_RX, RAM_RFS} dms_ram_sel_t;
	typedef enum logic [1:0] {FO_A, FO_B, FO_JDR, FO_FDR} dms_fo_sel_t;
	typedef enum logic [2:0] {RFS_A, RFS_C0, RFS_C4, RFS_C8, RFS_C12} dms_rfs_sel_t;

	// ----------------------------------------
	// All held selections
	// ----------------------------------------
	typedef struct packed {
		dms_ram_sel_t ram;
		dms_fo_sel_t  fo;
		logic [1:0]   rx;   // [1] first select line, [0] second
		logic [1:0]   tx;   // [0] TM1, [1] TM2
		dms_rfs_sel_t refresh_store;
		logic         tbs;  // Test-bit stage: 1 = A register
	} dms_sel_t;

endpackage : dms_pkg

`default_nettype wire

// >>> dms_decoder.sv
// Data-path mux select decoder with its AXI4-Lite control and status registers.
// Assumes opcodes and timing slots come from a sequencer on i_mclk.
//
// Summary of operation
// - D0 at slot T12 routes A register through first-operand and RAM input mux.
// - D3 is like D0 but selects the field definition register.
// - D4 at T12 passes keystroke data to RAM, stored at location 30.
// - D8 at T12 passes the twelve-bit received word into RAM.
// - DC passes eight-bit refresh storage read data into RAM.
// - E0 to E3 drive a two-bit receive select code to the far mux.
// - E0 sets receive code 00: terminal address information.
// - E0 also sets transmit select 000: pad character FF.
// - E1 sets receive code 10: receiver status information.
// - E2 sets receive code 01: eight received character bits.
// - E3 sets receive code 11: check character plus four character bits.
// - E4 sets transmit select 100: acknowledge character 0E.
// - E8 sets transmit select 010: first-operand bits 4 to 11.
// - EC sets transmit select 110: first-operand bits 0 to 3.
// - Error display enable latch drives the top transmit select line.
// - With error display on, transmit mux passes A register combinations.
// - F0 to F4 choose refresh write data; F0 gives A bits 0-7.
// - Nibble selections put C nibble on bits 0-3, bits 4-7 one.
// - Last selection puts C bit 12 on bit 0, bits 1-7 zero.
// - F8 leaves refresh data alone and selects A register for test bits.
// - Test-bit first stage takes status on F0 and A register on F8.
//
// The AXI4-Lite register port and the address map were left to the implementer.
`default_nettype none

module dms_decoder
	import dms_pkg::*;
#(
	parameter int W = 12
)(
	// Clock and reset
	input  wire logic          i_mclk,
	input  wire logic          i_sys_rst,
	// Sequencer
	input  wire logic [7:0]    i_opcode,
	input  wire logic          i_op_valid,
	input  wire logic [3:0]    i_tslot,
	// Data sources
	input  wire logic [W-1:0]  i_a_reg_bits,
	input  wire logic [W-1:0]  i_b_reg_bits,
	input  wire logic [W-1:0]  i_job_def_reg,
	input  wire logic [W-1:0]  i_field_def_reg,
	input  wire logic [W:0]    i_c_reg_bits,
	input  wire logic [7:0]    i_keystroke,
	input  wire logic [W-1:0]  i_received_word,
	input  wire logic [7:0]    i_refresh_read_bus,
	input  wire logic [W-1:0]  i_status_bits,
	// Mux selections and data
	output logic [W-1:0]       o_first_operand_bits,
	output logic [W-1:0]       o_ram_in_data,
	output logic               o_ram_addr_fixed,
	output logic [7:0]         o_ram_fixed_addr,
	output logic               o_rx_select_a,
	output logic               o_rx_select_b,
	output logic [2:0]         o_tx_select_lines,
	output logic [7:0]         o_tx_char_bits,
	output logic               o_error_display_enable,
	output logic [7:0]         o_refresh_write_bus,
	output logic               o_test_bit_selector,
	output logic [W-1:0]       o_test_bit_data,
	// AXI4-Lite slave
	input  wire logic [3:0]    s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [3:0]    s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready
);

	// Refuse widths that the fixed bit slices below cannot serve
	if (W != 12)
		$error("dms_decoder serves twelve-bit registers only");

	// ----------------------------------------
	// Decode strobe
	// ----------------------------------------
	logic       dec_en;
	logic       error_display_enable;
	logic [7:0] last_op;
	dms_sel_t   sel;
	logic       exec;
	// Opcodes act only at slot T12 and while software enables decoding
	assign exec = i_op_valid && (i_tslot == `DMS_SLOT_T12) && dec_en;

	// ----------------------------------------
	// Selection latches
	// ----------------------------------------
	// RAM input and first-operand selections
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			sel.ram <= RAM_A;
			sel.fo  <= FO_A;
		end
		else if (exec)
		begin
			unique case (i_opcode)
				`DMS_OP_D0: begin sel.ram <= RAM_A;   sel.fo <= FO_A;   end
				`DMS_OP_D1: begin sel.ram <= RAM_B;   sel.fo <= FO_B;   end
				`DMS_OP_D2: begin sel.ram <= RAM_JDR; sel.fo <= FO_JDR; end
				`DMS_OP_D3: begin sel.ram <= RAM_FDR; sel.fo <= FO_FDR; end
				`DMS_OP_D4: sel.ram <= RAM_KS;
				`DMS_OP_D8: sel.ram <= RAM_RX;
				`DMS_OP_DC: sel.ram <= RAM_RFS;
				default: ;
			endcase
		end
	end

	// Receive and transmit selections
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			sel.rx <= 2'h0;
			sel.tx <= 2'h0;
		end
		else if (exec)
		begin
			unique case (i_opcode)
				`DMS_OP_E0: begin sel.rx <= 2'h0; sel.tx <= 2'h0; end
				`DMS_OP_E1: sel.rx <= 2'h2;
				`DMS_OP_E2: sel.rx <= 2'h1;
				`DMS_OP_E3: sel.rx <= 2'h3;
				`DMS_OP_E4: sel.tx <= 2'h1;
				`DMS_OP_E8: sel.tx <= 2'h2;
				`DMS_OP_EC: sel.tx <= 2'h3;
				default: ;
			endcase
		end
	end

	// Refresh write and test-bit selections; F8 leaves the refresh source alone
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			sel.refresh_store <= RFS_A;
			sel.tbs <= 1'b0;
		end
		else if (exec)
		begin
			unique case (i_opcode)
				`DMS_OP_F0: begin sel.refresh_store <= RFS_A; sel.tbs <= 1'b0; end
				`DMS_OP_F1: sel.refresh_store <= RFS_C0;
				`DMS_OP_F2: sel.refresh_store <= RFS_C4;
				`DMS_OP_F3: sel.refresh_store <= RFS_C8;
				`DMS_OP_F4: sel.refresh_store <= RFS_C12;
				`DMS_OP_F8: sel.tbs <= 1'b1;
				default: ;
			endcase
		end
	end

	// Error display enable latch
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
			error_display_enable <= 1'b0;
		else if (exec && (i_opcode == `DMS_OP_ERE_SET || i_opcode == `DMS_OP_ERE_CLR))
			error_display_enable <= (i_opcode == `DMS_OP_ERE_SET);
	end

	// Last opcode accepted, for software
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
			last_op <= 8'h00;
		else if (exec)
			last_op <= i_opcode;
	end

	// ----------------------------------------
	// Data multiplexers
	// ----------------------------------------
	function automatic logic [W-1:0] fo_pick(input dms_fo_sel_t s, input logic [W-1:0] a, b, j, f);
		unique case (s)
			FO_A:   fo_pick = a;
			FO_B:   fo_pick = b;
			FO_JDR: fo_pick = j;
			FO_FDR: fo_pick = f;
		endcase
	endfunction : fo_pick

	wire logic [W-1:0] fo_now = fo_pick(sel.fo, i_a_reg_bits, i_b_reg_bits, i_job_def_reg, i_field_def_reg);

	// First-operand and RAM input data
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			o_first_operand_bits <= 12'h000;
			o_ram_in_data        <= 12'h000;
		end
		else
		begin
			o_first_operand_bits <= fo_now;
			unique case (sel.ram)
				RAM_KS:  o_ram_in_data <= {4'h0, i_keystroke};
				RAM_RX:  o_ram_in_data <= i_received_word;
				RAM_RFS: o_ram_in_data <= {4'h0, i_refresh_read_bus};
				default: o_ram_in_data <= fo_now;
			endcase
		end
	end

	// Transmit character; error display swaps in A register combinations
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
			o_tx_char_bits <= `DMS_PAD_CHAR;
		else if (error_display_enable)
		begin
			unique case (sel.tx)
				2'h0: o_tx_char_bits <= i_a_reg_bits[7:0];
				2'h1: o_tx_char_bits <= {4'h0, i_a_reg_bits[11:8]};
				2'h2: o_tx_char_bits <= i_a_reg_bits[11:4];
				2'h3: o_tx_char_bits <= {i_a_reg_bits[3:0], 4'h0};
			endcase
		end
		else
		begin
			unique case (sel.tx)
				2'h0: o_tx_char_bits <= `DMS_PAD_CHAR;
				2'h1: o_tx_char_bits <= `DMS_ACK_CHAR;
				2'h2: o_tx_char_bits <= fo_now[11:4];
				2'h3: o_tx_char_bits <= {4'h0, fo_now[3:0]};
			endcase
		end
	end

	// Refresh write data and test-bit first stage
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			o_refresh_write_bus <= 8'h00;
			o_test_bit_data     <= 12'h000;
		end
		else
		begin
			unique case (sel.refresh_store)
				RFS_A:   o_refresh_write_bus <= i_a_reg_bits[7:0];
				RFS_C0:  o_refresh_write_bus <= {4'hf, i_c_reg_bits[3:0]};
				RFS_C4:  o_refresh_write_bus <= {4'hf, i_c_reg_bits[7:4]};
				RFS_C8:  o_refresh_write_bus <= {4'hf, i_c_reg_bits[11:8]};
				RFS_C12: o_refresh_write_bus <= {7'h00, i_c_reg_bits[12]};
				default: o_refresh_write_bus <= 8'h00;
			endcase
			o_test_bit_data <= sel.tbs ? i_a_reg_bits : i_status_bits;
		end
	end

	// Select lines straight from the latches; the fixed RAM address is the constant keystroke location
	assign o_rx_select_a          = sel.rx[1];
	assign o_rx_select_b          = sel.rx[0];
	assign o_tx_select_lines      = {error_display_enable, sel.tx[1], sel.tx[0]};
	assign o_error_display_enable = error_display_enable;
	assign o_test_bit_selector    = sel.tbs;
	assign o_ram_addr_fixed       = (sel.ram == RAM_KS);
	assign o_ram_fixed_addr       = `DMS_KS_RAM_ADDR;

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	// Write taken when address and data are both offered and no response is pending
	assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_wready  = s_axi_awready;
	assign s_axi_arready = !s_axi_rvalid;

	// Control register and write response
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			dec_en       <= `DMS_CTRL_RST;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end
		else if (s_axi_awready)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (s_axi_awaddr == `DMS_OFS_CTRL) ? 2'h0 : 2'h2;
			if (s_axi_awaddr == `DMS_OFS_CTRL && s_axi_wstrb[0])
				dec_en <= s_axi_wdata[0];
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Read data and response
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'h0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'h0;
			s_axi_rdata  <= 32'h0000_0000;                                // Unmapped reads return zero
			unique case (s_axi_araddr)
				`DMS_OFS_CTRL:   s_axi_rdata <= {31'h0, dec_en};
				`DMS_OFS_STATUS: s_axi_rdata <= {18'h0, error_display_enable, sel};
				`DMS_OFS_LASTOP: s_axi_rdata <= {24'h0, last_op};
				default:         s_axi_rresp <= 2'h2;
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_d3_fdr_path: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		exec && i_opcode == `DMS_OP_D3 |-> ##2 o_ram_in_data == $past(i_field_def_reg))
		else $error("D3 did not route the field definition register");
	a_ks_fixed_addr: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		exec && i_opcode == `DMS_OP_D4 |=> o_ram_addr_fixed && o_ram_fixed_addr == 8'h30)
		else $error("D4 did not select keystroke location");
	a_rx_code_e1: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		exec && i_opcode == `DMS_OP_E1 |=> o_rx_select_a && !o_rx_select_b)
		else $error("E1 receive code wrong");
	a_rx_code_e2: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		exec && i_opcode == `DMS_OP_E2 |=> !o_rx_select_a && o_rx_select_b)
		else $error("E2 receive code wrong");
	a_tx_ack_char: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		exec && i_opcode == `DMS_OP_E4 && !error_display_enable |=> o_tx_select_lines == 3'h1 ##1 o_tx_char_bits == 8'h0e)
		else $error("E4 did not give the acknowledge character");
	a_tx_msb_ere: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		exec && i_opcode == `DMS_OP_ERE_SET |=> o_tx_select_lines[2] && o_error_display_enable)
		else $error("Error display latch not on top transmit line");
	a_rfs_nibble: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		sel.refresh_store == RFS_C4 |=> o_refresh_write_bus == {4'hf, $past(i_c_reg_bits[7:4])})
		else $error("Refresh nibble data wrong");
	a_rfs_bit12: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		exec && i_opcode == `DMS_OP_F4 |-> ##2 o_refresh_write_bus[7:1] == 7'h00)
		else $error("Refresh bit-12 upper bits not zero");
	a_f8_keeps_rfs: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		exec && i_opcode == `DMS_OP_F8 |=> o_test_bit_selector && $stable(sel.refresh_store))
		else $error("F8 disturbed refresh data or missed test select");
	a_hold_select: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		!exec |=> $stable(sel) && $stable(error_display_enable))
		else $error("Selection changed without an opcode");

endmodule : dms_decoder

`default_nettype wire

// >>> dms_trx_model.sv
// Behavioural receive mux of the transmit/receive board facing the decoder.
// Assumes the decoder drives the two receive select lines; the mux settles at once.
`default_nettype none

module dms_trx_model
#(
	parameter logic [11:0] ADDR_INFO = 12'h015,
	parameter logic [11:0] RX_STATUS = 12'h803,
	parameter logic [7:0]  RX_CHAR   = 8'ha5,
	parameter logic [7:0]  CHECK     = 8'h3c
)(
	// Receive select lines
	input  wire logic        i_rx_select_a,
	input  wire logic        i_rx_select_b,
	// Received word toward the decoder
	output logic [11:0]      o_received_word
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// Receive mux
	// ----------------------------------------
	// Code is first line then second line
	always_comb
	begin
		case ({i_rx_select_a, i_rx_select_b})
			2'b00:   o_received_word = ADDR_INFO;
			2'b10:   o_received_word = RX_STATUS;
			2'b01:   o_received_word = {4'h0, RX_CHAR};
			default: o_received_word = {CHECK, RX_CHAR[3:0]};
		endcase
	end

endmodule : dms_trx_model

`default_nettype wire

// >>> datapath_mux_select_decoder_test.sv
// Self-checking bench for the mux select decoder: opcode and AXI4-Lite tasks.
// Assumes dms_cfg.svh, the package, the decoder and the receive model compile first.
`default_nettype none
`include "dms_cfg.svh"

module datapath_mux_select_decoder_test;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// Source values and expectations
	// ----------------------------------------
	localparam logic [11:0] A_V = 12'h5a3, B_V = 12'h6c1, JD_V = 12'h9e2, FD_V = 12'h3b7, ST_V = 12'h2f1;
	localparam logic [12:0] C_V = 13'h1d4c;
	localparam logic [7:0]  KS_V = 8'h7e, RD_V = 8'h96;
	localparam logic [1:0]  RX_CODE [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
	localparam logic [11:0] RX_WORD [4] = '{12'h015, 12'h803, 12'h0a5, 12'h3c5};
	localparam logic [7:0]  TX_EXP [8] = '{8'hff, 8'h0e, B_V[11:4], {4'h0, B_V[3:0]},
		A_V[7:0], {4'h0, A_V[11:8]}, A_V[11:4], {A_V[3:0], 4'h0}};
	localparam logic [7:0]  RF_EXP [5] = '{A_V[7:0], {4'hf, C_V[3:0]}, {4'hf, C_V[7:4]},
		{4'hf, C_V[11:8]}, {7'h0, C_V[12]}};

	logic        clk, rst, op_valid, fixed, rx_a, rx_b, err_en, tbs;
	logic [7:0]  opcode, fixed_addr, tx_char, wr_bus;
	logic [3:0]  tslot, awaddr, araddr, wstrb;
	logic [11:0] rx_word, fo_bits, ram_data, tb_data;
	logic [2:0]  tx_sel;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, rd;
	logic [1:0]  bresp, rresp, rr;
	int          n_fail, n_compared, n_cycles;

	// ----------------------------------------
	// Device and far side
	// ----------------------------------------
	dms_decoder i_dut (
		.i_mclk (clk), .i_sys_rst (rst),
		.i_opcode (opcode), .i_op_valid (op_valid), .i_tslot (tslot),
		.i_a_reg_bits (A_V), .i_b_reg_bits (B_V), .i_job_def_reg (JD_V), .i_field_def_reg (FD_V),
		.i_c_reg_bits (C_V), .i_keystroke (KS_V), .i_received_word (rx_word),
		.i_refresh_read_bus (RD_V), .i_status_bits (ST_V),
		.o_first_operand_bits (fo_bits), .o_ram_in_data (ram_data), .o_ram_addr_fixed (fixed),
		.o_ram_fixed_addr (fixed_addr), .o_rx_select_a (rx_a), .o_rx_select_b (rx_b),
		.o_tx_select_lines (tx_sel), .o_tx_char_bits (tx_char), .o_error_display_enable (err_en),
		.o_refresh_write_bus (wr_bus), .o_test_bit_selector (tbs), .o_test_bit_data (tb_data),
		.s_axi_awaddr (awaddr), .s_axi_awvalid (awvalid), .s_axi_awready (awready),
		.s_axi_wdata (wdata), .s_axi_wstrb (wstrb), .s_axi_wvalid (wvalid), .s_axi_wready (wready),
		.s_axi_bresp (bresp), .s_axi_bvalid (bvalid), .s_axi_bready (bready),
		.s_axi_araddr (araddr), .s_axi_arvalid (arvalid), .s_axi_arready (arready),
		.s_axi_rdata (rdata), .s_axi_rresp (rresp), .s_axi_rvalid (rvalid), .s_axi_rready (rready)
	);

	dms_trx_model i_trx (.i_rx_select_a (rx_a), .i_rx_select_b (rx_b), .o_received_word (rx_word));

	// ----------------------------------------
	// Clock and hang guard
	// ----------------------------------------
	always #4 clk = ~clk;

	// Cuts a hung run short
	always @(posedge clk)
	begin
		n_cycles <= n_cycles + 1;
		if (n_cycles == 3000)
		begin
			n_fail++;
			conclude();
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic conclude();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One opcode at a slot; returns once data outputs show the new selection
	task automatic op(input logic [7:0] code, input logic [3:0] slot = `DMS_SLOT_T12);
		@(posedge clk);
		opcode <= code;
		tslot <= slot;
		op_valid <= 1'b1;
		@(posedge clk);
		op_valid <= 1'b0;
		tslot <= 4'h0;
		repeat (2) @(posedge clk);
		#1;
	endtask : op

	task automatic axw(input logic [3:0] addr, input logic [31:0] data, input logic [1:0] exp);
		@(posedge clk);
		awaddr <= addr;
		wdata <= data;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge clk); while (!(awready && wready));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
		chk(bresp, exp);
	endtask : axw

	task automatic axr(input logic [3:0] addr, output logic [31:0] data, output logic [1:0] resp);
		@(posedge clk);
		araddr <= addr;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		data = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : axr

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{clk, op_valid, awvalid, wvalid, bready, arvalid, rready} = '0;
		{opcode, tslot, awaddr, araddr, wstrb, wdata} = '0;
		{n_fail, n_compared, n_cycles} = '0;
		rst = 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk({err_en, tx_sel, tx_char}, 12'h0ff);
		axr(`DMS_OFS_CTRL, rd, rr);
		chk({rr, rd}, 34'h1);
		axr(`DMS_OFS_STATUS, rd, rr);
		chk({rr, rd}, 34'h0);
		// RAM input and first operand mux
		op(`DMS_OP_D0);
		chk({fo_bits, ram_data}, {A_V, A_V});
		op(`DMS_OP_D3);
		chk({fo_bits, ram_data}, {FD_V, FD_V});
		op(`DMS_OP_D2);
		chk({fo_bits, ram_data}, {JD_V, JD_V});
		op(`DMS_OP_D4);
		chk({fixed, fixed_addr, ram_data}, {1'b1, 8'h30, 4'h0, KS_V});
		op(`DMS_OP_DC);
		chk({fixed, ram_data}, {1'b0, 4'h0, RD_V});
		op(`DMS_OP_D8);
		// Receive select codes reach the far mux and come back as RAM data
		for (int i = 0; i < 4; i++)
		begin
			op(`DMS_OP_E0 + 8'(i));
			chk({rx_a, rx_b, ram_data}, {RX_CODE[i], RX_WORD[i]});
		end
		// Transmit mux, normal then with error display enabled
		op(`DMS_OP_D1);
		for (int e = 0; e < 2; e++)
		begin
			if (e == 1)
				op(`DMS_OP_ERE_SET);
			for (int i = 0; i < 4; i++)
			begin
				op(`DMS_OP_E0 + 8'(4 * i));
				chk({err_en, tx_sel, tx_char}, {e[0], e[0], i[1:0], TX_EXP[4 * e + i]});
			end
		end
		op(`DMS_OP_ERE_CLR);
		chk({err_en, tx_sel}, 4'h3);
		// Refresh write data
		for (int i = 0; i < 5; i++)
		begin
			op(`DMS_OP_F0 + 8'(i));
			chk({tbs, wr_bus}, {1'b0, RF_EXP[i]});
		end
		op(`DMS_OP_F8);
		chk({tbs, tb_data, wr_bus}, {1'b1, A_V, RF_EXP[4]});
		op(`DMS_OP_F0);
		chk({tbs, tb_data, wr_bus}, {1'b0, ST_V, RF_EXP[0]});
		chk({rx_a, rx_b, tx_sel, fo_bits}, {5'h03, B_V});
		// Ignored requests: wrong slot, then decode disabled
		op(`DMS_OP_D0, 4'hb);
		chk(ram_data, B_V);
		axw(`DMS_OFS_CTRL, 32'h0, 2'b00);
		op(`DMS_OP_D0);
		chk(ram_data, B_V);
		axw(`DMS_OFS_CTRL, 32'h1, 2'b00);
		op(`DMS_OP_D0);
		chk(ram_data, A_V);
		axr(`DMS_OFS_LASTOP, rd, rr);
		chk({rr, rd}, {2'b00, 24'h0, `DMS_OP_D0});
		// Unmapped register
		axw(4'hc, 32'h5, 2'b10);
		axr(4'hc, rd, rr);
		chk({rr, rd}, {2'b10, 32'h0});
		conclude();
	end

endmodule : datapath_mux_select_decoder_test

`default_nettype wire
